// ===== common/mdsc_pkg.sv
package mdsc_pkg;

  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PHASE_W = 16;

  // Register offsets
  localparam logic [2:0] OFS_CONFIG = 3'h0;
  localparam logic [2:0] OFS_PHASE_LO = 3'h1;
  localparam logic [2:0] OFS_PHASE_HI = 3'h2;
  localparam logic [2:0] OFS_PERIOD_CNT = 3'h3;
  localparam logic [2:0] OFS_PERIOD = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;

  // Values after reset
  localparam logic [7:0] CONFIG_RESET = 8'h40;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h27;
  localparam logic [7:0] PERIOD_CNT_RESET = 8'h00;

  // Field positions in the configuration register
  localparam int BIT_CLAMP_SRC = 7;
  localparam int BIT_VGND = 6;
  localparam int BIT_KEEP_ON = 5;
  localparam int BIT_CUR_REG = 4;
  localparam int BIT_AMP_CLAMP = 3;
  localparam int ROLE_LSB = 0;
  localparam int ROLE_W = 3;

  // System role codes
  localparam logic [2:0] ROLE_ALONE = 3'h0;
  localparam logic [2:0] ROLE_MO_MASTER = 3'h1;
  localparam logic [2:0] ROLE_MO_SLAVE = 3'h2;
  localparam logic [2:0] ROLE_MP_MASTER = 3'h3;
  localparam logic [2:0] ROLE_MP_SLAVE = 3'h4;
  localparam logic [2:0] ROLE_MO_MASTER_SYNC = 3'h5;
  localparam logic [2:0] ROLE_MO_SLAVE_SYNC = 3'h6;
  localparam logic [2:0] ROLE_UNUSED = 3'h7;

  // Shared system clock derived from the 40 MHz core clock
  localparam int CLK_SYS_HZ = 40_000_000;
  localparam int SYSCLK_HZ = 8_000_000;
  localparam int SYSCLK_DIV = CLK_SYS_HZ / SYSCLK_HZ;
  localparam logic [2:0] SYSCLK_DIV_LAST = 3'(SYSCLK_DIV - 1);
  localparam logic [2:0] SYSCLK_DIV_HIGH = 3'(SYSCLK_DIV / 2);

  // Configuration register, laid out as the bits sit
  typedef struct packed {
    logic clamp_src;
    logic vgnd_en;
    logic keep_on;
    logic cur_reg;
    logic amp_clamp;
    logic [2:0] role;
  } mdsc_cfg_t;

  // Which shared pins the role claims, and in which direction
  typedef struct packed {
    logic sync_out;
    logic sync_in;
    logic clk_out;
    logic clk_in;
    logic dem_out;
    logic dem_in;
  } mdsc_pinrole_t;

  // Output half of a two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } mdsc_pad_t;

  // Role code to pin directions; 111 claims nothing
  function automatic mdsc_pinrole_t mdsc_role_f(input logic [2:0] code);
    mdsc_pinrole_t r;
    r = '0;
    case (code)
      ROLE_MO_MASTER: r = '{sync_out: 1'b1, clk_out: 1'b1, default: 1'b0};
      ROLE_MO_SLAVE: r = '{sync_in: 1'b1, clk_in: 1'b1, default: 1'b0};
      ROLE_MP_MASTER: r = '{sync_out: 1'b1, clk_out: 1'b1, dem_out: 1'b1, default: 1'b0};
      ROLE_MP_SLAVE: r = '{sync_in: 1'b1, clk_in: 1'b1, dem_in: 1'b1, default: 1'b0};
      ROLE_MO_MASTER_SYNC: r = '{sync_out: 1'b1, default: 1'b0};
      ROLE_MO_SLAVE_SYNC: r = '{sync_in: 1'b1, default: 1'b0};
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

// ===== src/mdsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module mdsc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two flops; the first is read by the second alone
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== src/mdsc_sync_config.sv
// Behaviour
// [R1] Low three config bits pick the role; 000 runs alone, sync pins unused.
// [R2] Role 001 drives sync out and the 8 MHz clock out.
// [R3] Role 101 drives only sync out; clock pin stays general purpose.
// [R4] Role 010 takes sync and 8 MHz clock as inputs from master.
// [R5] Role 110 takes only sync as input; own clock kept.
// [R6] Role 011 drives sync, clock and the sampled demand out.
// [R7] Role 100 takes sync, clock and demand in; demand becomes regulation target.
// [R8] Master sync frequency is the switching frequency; slave follows received sync.
// [R9] Slave delays its cycle after sync by the two-byte phase value.
// [R10] Firmware clears the period counter before synchronised operation.
// [R11] Firmware sets current regulation for multi-phase slave operation.
// [R12] Bit 7 picks clamp level: pin alone, or pin with average current.
// [R13] Bit 6 enables virtual ground; it alone resets to one.
// [R14] Bit 5 keeps the regulator on in sleep, else low current.
// [R15] Bit 4 picks current regulation when set, voltage when clear.
// [R16] Bit 3 enables the error amplifier output clamp.
// [R17] Code 111 behaves as stand-alone, pins under general purpose control.
`timescale 1ns/1ps
`default_nettype none

module mdsc_sync_config #(
  parameter logic [7:0] PERIOD_DEFAULT = mdsc_pkg::PERIOD_RESET
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [mdsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mdsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mdsc_pkg::DATA_W-1:0] reg_rdata,
  // Shared pins, input side and driven side
  input wire logic sync_pin_i,
  output mdsc_pkg::mdsc_pad_t sync_pin,
  input wire logic sysclk_share_pin_i,
  output mdsc_pkg::mdsc_pad_t sysclk_share_pin,
  input wire logic demand_share_pin_i,
  output mdsc_pkg::mdsc_pad_t demand_share_pin,
  // General purpose drive requests for pins the role leaves free
  input wire mdsc_pkg::mdsc_pad_t gpio_sync,
  input wire mdsc_pkg::mdsc_pad_t gpio_sysclk,
  input wire mdsc_pkg::mdsc_pad_t gpio_demand,
  // Loop side
  input wire logic sampled_demand,
  input wire logic sleep_cmd,
  output logic clamp_source_select,
  output logic vgnd_enable,
  output logic ldo_low_current,
  output logic current_regulation_select,
  output logic amp_clamp_enable,
  output logic regulation_demand,
  output logic switch_cycle_start,
  output logic sysclk_tick
);

  import mdsc_pkg::*;

  typedef enum logic {MDSC_ALIGN_IDLE, MDSC_ALIGN_DELAY} mdsc_align_t;

  mdsc_cfg_t cfg_q;
  logic [DATA_W-1:0] phase_lo_q;
  logic [DATA_W-1:0] phase_hi_q;
  logic [DATA_W-1:0] period_q;
  logic [DATA_W-1:0] per_cnt_q;
  logic [DATA_W-1:0] rdata_q;
  logic [PHASE_W-1:0] phase_w;
  logic [PHASE_W-1:0] delay_q;
  mdsc_align_t align_q;
  mdsc_pinrole_t role_w;
  logic master_w;
  logic slave_w;
  logic [3:0] raw_w;
  logic [3:0] syn_w;
  logic sync_s;
  logic clk_s;
  logic dem_pin_s;
  logic dem_s;
  logic sync_prev_q;
  logic clk_prev_q;
  logic sync_rise_w;
  logic ext_tick_w;
  logic int_tick_w;
  logic tick_w;
  logic [2:0] div_q;
  logic int_clk_w;
  logic sync_level_w;
  logic wr_cfg_w;
  logic wr_cnt_w;
  logic start_d;
  logic start_q;
  logic ldo_low_q;
  logic demand_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs into the core clock domain

  assign raw_w = {sampled_demand, demand_share_pin_i, sysclk_share_pin_i, sync_pin_i};

  mdsc_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(raw_w),
    .sync_out(syn_w)
  );

  assign sync_s = syn_w[0];
  assign clk_s = syn_w[1];
  assign dem_pin_s = syn_w[2];
  assign dem_s = syn_w[3];

  // Edge history, taken only from synchronised levels
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_prev_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      sync_prev_q <= sync_s;
      clk_prev_q <= clk_s;
    end
  end

  assign sync_rise_w = sync_s & ~sync_prev_q;
  assign ext_tick_w = clk_s & ~clk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  assign wr_cfg_w = reg_wr && (reg_addr == OFS_CONFIG);
  assign wr_cnt_w = reg_wr && (reg_addr == OFS_PERIOD_CNT);
  assign phase_w = {phase_hi_q, phase_lo_q};

  // Configuration and phase registers; virtual ground alone resets set
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg_q <= CONFIG_RESET; // R13
      phase_lo_q <= PHASE_RESET;
      phase_hi_q <= PHASE_RESET;
      period_q <= PERIOD_DEFAULT;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_CONFIG: cfg_q <= reg_wdata; // R1
        OFS_PHASE_LO: phase_lo_q <= reg_wdata; // R9
        OFS_PHASE_HI: phase_hi_q <= reg_wdata; // R9
        OFS_PERIOD: period_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  reset_vgnd_a: assert property ($fell(reset) |-> vgnd_enable && !amp_clamp_enable && cfg_q.role == ROLE_ALONE) // R13
    else $error("virtual ground not alone set after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Role decode

  assign role_w = mdsc_role_f(cfg_q.role); // R1 R17
  assign master_w = role_w.sync_out;
  assign slave_w = role_w.sync_in;

  ////////////////////////////////////////////////////////////////////////////
  // System clock: own 8 MHz divider, or the master's clock when shared in

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      div_q <= '0;
    else if (div_q == SYSCLK_DIV_LAST)
      div_q <= '0;
    else
      div_q <= div_q + 3'h1;
  end

  // Five core cycles per period, so the clock out is 2/5 duty
  assign int_clk_w = div_q < SYSCLK_DIV_HIGH;
  assign int_tick_w = div_q == SYSCLK_DIV_LAST;
  assign tick_w = role_w.clk_in ? ext_tick_w : int_tick_w; // R4 R5
  assign sysclk_tick = tick_w;

  clk_source_a: assert property (cfg_q.role == ROLE_MO_SLAVE |-> tick_w == ext_tick_w) // R4
    else $error("clock slave not timed by shared clock");

  own_clock_a: assert property (cfg_q.role == ROLE_MO_SLAVE_SYNC |-> tick_w == int_tick_w) // R5
    else $error("sync only slave not timed by own clock");

  ////////////////////////////////////////////////////////////////////////////
  // Period counter; a write wins so firmware can clear it before locking

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      per_cnt_q <= PERIOD_CNT_RESET;
    else if (wr_cnt_w)
      per_cnt_q <= reg_wdata; // R10
    else if (start_d)
      per_cnt_q <= '0;
    else if (tick_w)
      per_cnt_q <= per_cnt_q + 8'h01;
  end

  // Sync out is high while the period count is at most half the period value
  assign sync_level_w = per_cnt_q <= (period_q >> 1);

  ////////////////////////////////////////////////////////////////////////////
  // Slave alignment: a received sync edge starts the cycle after the phase
  // delay; a new edge during the delay restarts it, so jitter cannot pile up

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      align_q <= MDSC_ALIGN_IDLE;
      delay_q <= '0;
    end
    else if (!slave_w)
    begin
      align_q <= MDSC_ALIGN_IDLE;
      delay_q <= '0;
    end
    else if (sync_rise_w && phase_w != '0)
    begin
      align_q <= MDSC_ALIGN_DELAY; // R9
      delay_q <= phase_w;
    end
    else
    begin
      case (align_q)
        MDSC_ALIGN_IDLE: align_q <= MDSC_ALIGN_IDLE;
        MDSC_ALIGN_DELAY:
        begin
          if (tick_w && delay_q == 16'h0001)
            align_q <= MDSC_ALIGN_IDLE;
          if (tick_w)
            delay_q <= delay_q - 16'h0001;
        end
        default: align_q <= MDSC_ALIGN_IDLE;
      endcase
    end
  end

  // Cycle start: master wraps its own period, slave follows the sync
  always_comb
  begin
    start_d = 1'b0;
    if (slave_w)
    begin
      if (sync_rise_w && phase_w == '0)
        start_d = 1'b1; // R8
      else if (align_q == MDSC_ALIGN_DELAY && tick_w && delay_q == 16'h0001 && !sync_rise_w)
        start_d = 1'b1; // R9
    end
    else if (tick_w && per_cnt_q >= period_q)
      start_d = 1'b1; // R8
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      start_q <= 1'b0;
    else
      start_q <= start_d;
  end

  assign switch_cycle_start = start_q;

  sequence s_zero_phase_sync;
    slave_w && sync_rise_w && phase_w == '0;
  endsequence

  sequence s_shifted_sync;
    slave_w && sync_rise_w && phase_w != '0;
  endsequence

  slave_follow_a: assert property (s_zero_phase_sync |=> switch_cycle_start) // R8
    else $error("slave missed cycle start on sync edge");

  phase_delay_a: assert property (s_shifted_sync |=> !switch_cycle_start && align_q == MDSC_ALIGN_DELAY) // R9
    else $error("phase shift not applied after sync edge");

  master_period_a: assert property (!slave_w && !wr_cnt_w && tick_w && per_cnt_q >= period_q |=> // R8
    switch_cycle_start && per_cnt_q == '0)
    else $error("master period did not wrap");

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin drive: claimed outputs driven, claimed inputs released,
  // free pins follow their general purpose request

  mdsc_pad_t gpio_w [3];
  mdsc_pad_t pad_q [3];
  logic use_out_w [3];
  logic use_in_w [3];
  logic drv_w [3];

  assign gpio_w[0] = gpio_sync;
  assign gpio_w[1] = gpio_sysclk;
  assign gpio_w[2] = gpio_demand;
  assign use_out_w[0] = role_w.sync_out; // R2 R3 R6
  assign use_out_w[1] = role_w.clk_out; // R2 R6
  assign use_out_w[2] = role_w.dem_out; // R6
  assign use_in_w[0] = role_w.sync_in; // R4 R5 R7
  assign use_in_w[1] = role_w.clk_in; // R4 R7
  assign use_in_w[2] = role_w.dem_in; // R7
  assign drv_w[0] = sync_level_w;
  assign drv_w[1] = int_clk_w;
  assign drv_w[2] = dem_s;

  for (genvar g = 0; g < 3; g++)
  begin : g_pad
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        pad_q[g] <= '0;
      else if (use_out_w[g])
        pad_q[g] <= '{o: drv_w[g], oe: 1'b1};
      else if (use_in_w[g])
        pad_q[g] <= '0;
      else
        pad_q[g] <= gpio_w[g]; // R1 R17
    end
  end

  assign sync_pin = pad_q[0];
  assign sysclk_share_pin = pad_q[1];
  assign demand_share_pin = pad_q[2];

  alone_pins_a: assert property (cfg_q.role == ROLE_ALONE |=>
    sync_pin == $past(gpio_sync) && sysclk_share_pin == $past(gpio_sysclk)
    && demand_share_pin == $past(gpio_demand)) // R1
    else $error("stand-alone role took a shared pin");

  unused_code_a: assert property (cfg_q.role == ROLE_UNUSED |=>
    sync_pin == $past(gpio_sync) && sysclk_share_pin == $past(gpio_sysclk)
    && demand_share_pin == $past(gpio_demand)) // R17
    else $error("code 111 did not act as stand-alone");

  mo_master_a: assert property (cfg_q.role == ROLE_MO_MASTER |=>
    sync_pin.oe && sync_pin.o == $past(sync_level_w) && sysclk_share_pin.oe
    && sysclk_share_pin.o == $past(int_clk_w) && demand_share_pin == $past(gpio_demand)) // R2
    else $error("multiple output master pins wrong");

  sync_only_a: assert property (cfg_q.role == ROLE_MO_MASTER_SYNC |=>
    sync_pin.oe && sysclk_share_pin == $past(gpio_sysclk)) // R3
    else $error("sync only master drove the clock pin");

  mo_slave_a: assert property (cfg_q.role == ROLE_MO_SLAVE |=>
    !sync_pin.oe && !sysclk_share_pin.oe && demand_share_pin == $past(gpio_demand)) // R4
    else $error("multiple output slave drove a shared pin");

  sync_slave_a: assert property (cfg_q.role == ROLE_MO_SLAVE_SYNC |=>
    !sync_pin.oe && sysclk_share_pin == $past(gpio_sysclk)) // R5
    else $error("sync only slave pins wrong");

  mp_master_a: assert property (cfg_q.role == ROLE_MP_MASTER |=>
    sync_pin.oe && sysclk_share_pin.oe && demand_share_pin.oe && demand_share_pin.o == $past(dem_s)) // R6
    else $error("multi-phase master demand not driven");

  ////////////////////////////////////////////////////////////////////////////
  // Regulation target: a multi-phase slave follows the master's demand

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      demand_q <= 1'b0;
    else if (role_w.dem_in)
      demand_q <= dem_pin_s; // R7
    else
      demand_q <= dem_s;
  end

  assign regulation_demand = demand_q;

  mp_slave_a: assert property (cfg_q.role == ROLE_MP_SLAVE |=>
    !demand_share_pin.oe && !sync_pin.oe && regulation_demand == $past(dem_pin_s)) // R7
    else $error("multi-phase slave not following shared demand");

  ////////////////////////////////////////////////////////////////////////////
  // Loop control bits

  assign clamp_source_select = cfg_q.clamp_src; // R12
  assign vgnd_enable = cfg_q.vgnd_en; // R13
  assign current_regulation_select = cfg_q.cur_reg; // R15 R11
  assign amp_clamp_enable = cfg_q.amp_clamp; // R16

  // Regulator drops to low current only on sleep with keep-on clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ldo_low_q <= 1'b0;
    else
      ldo_low_q <= sleep_cmd && !cfg_q.keep_on; // R14
  end

  assign ldo_low_current = ldo_low_q;

  clamp_src_a: assert property (wr_cfg_w |=> clamp_source_select == $past(reg_wdata[BIT_CLAMP_SRC])) // R12
    else $error("clamp source bit not taken");

  sleep_ldo_a: assert property (sleep_cmd && !cfg_q.keep_on |=> ldo_low_current) // R14
    else $error("regulator not lowered in sleep");

  keep_on_a: assert property (wr_cfg_w && reg_wdata[BIT_KEEP_ON] ##1 sleep_cmd |=> !ldo_low_current) // R14
    else $error("regulator lowered despite keep-on");

  cur_reg_a: assert property (wr_cfg_w |=> current_regulation_select == $past(reg_wdata[BIT_CUR_REG])) // R15
    else $error("regulation target bit not taken");

  amp_clamp_a: assert property (wr_cfg_w |=> amp_clamp_enable == $past(reg_wdata[BIT_AMP_CLAMP])) // R16
    else $error("amplifier clamp bit not taken");

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; data stand in the cycle after the strobe only

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata_q <= '0;
    else if (!reg_rd)
      rdata_q <= '0;
    else
    begin
      case (reg_addr)
        OFS_CONFIG: rdata_q <= cfg_q;
        OFS_PHASE_LO: rdata_q <= phase_lo_q;
        OFS_PHASE_HI: rdata_q <= phase_hi_q;
        OFS_PERIOD_CNT: rdata_q <= per_cnt_q;
        OFS_PERIOD: rdata_q <= period_q;
        OFS_STATUS: rdata_q <= {4'h0, align_q == MDSC_ALIGN_DELAY, slave_w, master_w, sync_s};
        default: rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ===== tb/mdsc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module mdsc_peer_model (
  // Control from the bench
  input wire logic run,
  input wire logic demand_level,
  // Lines towards the shared pins
  output logic clk_o,
  output logic sync_o,
  output logic demand_o
);
  int tick_n;

  initial
  begin
    clk_o = 1'b0;
    sync_o = 1'b0;
    demand_o = 1'b0;
    tick_n = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master timebase of 200 ns; sync high for 2 of every 20 ticks
  always
  begin
    #100;
    clk_o = ~clk_o;
    if (run)
    begin
      if (clk_o)
        tick_n = (tick_n + 1) % 20;
      sync_o = (tick_n < 2);
      demand_o = demand_level;
    end
    else
    begin
      // Released lines keep moving so a stale level is never mistaken for data
      tick_n = 0;
      sync_o = ~sync_o;
      demand_o = ~demand_o;
    end
  end
endmodule

`default_nettype wire

// ===== tb/mdsc_sync_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mdsc_sync_config_tb;
  import mdsc_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  mdsc_pad_t sync_pin, sysclk_share_pin, demand_share_pin;
  mdsc_pad_t gpio_free = '{o: 1'b1, oe: 1'b1};
  logic sampled_demand = 1'b0;
  logic sleep_cmd = 1'b0;
  logic clamp_source_select, vgnd_enable, ldo_low_current;
  logic current_regulation_select, amp_clamp_enable, regulation_demand;
  logic switch_cycle_start, sysclk_tick;
  logic peer_run = 1'b0;
  logic peer_dem = 1'b0;
  logic peer_clk, peer_sync, peer_demand;
  wire logic sync_w, clk_w, dem_w;
  int err_count = 0;
  int n_compared = 0;
  // Pin direction per role, 2 bits each for sync, clock, demand: 0 in, 1 out, 2 free
  logic [5:0] dirs [8] = '{6'h2a, 6'h16, 6'h02, 6'h15, 6'h00, 6'h1a, 6'h0a, 6'h2a};

  // Core clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  // Wire level from whichever party drives it
  assign sync_w = sync_pin.oe ? sync_pin.o : peer_sync;
  assign clk_w = sysclk_share_pin.oe ? sysclk_share_pin.o : peer_clk;
  assign dem_w = demand_share_pin.oe ? demand_share_pin.o : peer_demand;

  mdsc_sync_config dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_pin_i(sync_w), .sync_pin(sync_pin), .sysclk_share_pin_i(clk_w),
    .sysclk_share_pin(sysclk_share_pin), .demand_share_pin_i(dem_w),
    .demand_share_pin(demand_share_pin), .gpio_sync(gpio_free), .gpio_sysclk(gpio_free),
    .gpio_demand(gpio_free), .sampled_demand(sampled_demand), .sleep_cmd(sleep_cmd),
    .clamp_source_select(clamp_source_select), .vgnd_enable(vgnd_enable),
    .ldo_low_current(ldo_low_current), .current_regulation_select(current_regulation_select),
    .amp_clamp_enable(amp_clamp_enable), .regulation_demand(regulation_demand),
    .switch_cycle_start(switch_cycle_start), .sysclk_tick(sysclk_tick)
  );

  mdsc_peer_model peer (
    .run(peer_run), .demand_level(peer_dem), .clk_o(peer_clk), .sync_o(peer_sync),
    .demand_o(peer_demand)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register port master
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("MISMATCH at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic read_check(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check8(d, exp);
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return sync_pin.o;
      1: return sysclk_share_pin.o;
      2: return sysclk_tick;
      default: return switch_cycle_start;
    endcase
  endfunction

  // Rising edges of one output over a fixed span of cycles
  task automatic count_rises(input int sel, input int ncyc, output int n);
    logic prev;
    n = 0;
    #1;
    prev = sig(sel);
    repeat (ncyc)
    begin
      @(posedge clk_sys);
      #1;
      if (sig(sel) === 1'b1 && prev !== 1'b1)
        n++;
      prev = sig(sel);
    end
  endtask

  // Cycles from a rising sync level at the pin to the switching cycle start
  task automatic start_delay(output int d);
    d = 0;
    @(posedge peer_sync);
    while (switch_cycle_start !== 1'b1 && d < 400)
    begin
      @(posedge clk_sys);
      #1;
      d++;
    end
  endtask

  task automatic check_pad(input mdsc_pad_t p, input logic [1:0] dir);
    if (dir == 2'd1)
      check8({7'h0, p.oe}, 8'h01);
    else
      check8({6'h0, p}, (dir == 2'd0) ? 8'h00 : 8'h03);
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int n;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values and an unmapped place
    read_check(OFS_CONFIG, 8'h40);
    read_check(OFS_PHASE_LO, 8'h00);
    read_check(OFS_PHASE_HI, 8'h00);
    read_check(OFS_PERIOD, PERIOD_RESET);
    read_check(OFS_STATUS, 8'h01);
    reg_write(3'h6, 8'h5a);
    read_check(3'h6, 8'h00);
    check8({7'h0, vgnd_enable}, 8'h01);
    $display("test reset done");
    // Loop control bits and sleep
    reg_write(OFS_CONFIG, 8'hb8);
    read_check(OFS_CONFIG, 8'hb8);
    check8({3'h0, clamp_source_select, vgnd_enable, current_regulation_select, amp_clamp_enable, 1'b0},
           8'h16);
    sleep_cmd <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check8({7'h0, ldo_low_current}, 8'h00);
    reg_write(OFS_CONFIG, 8'h98);
    repeat (2) @(posedge clk_sys);
    #1;
    check8({7'h0, ldo_low_current}, 8'h01);
    // Keep-on set while asleep must lift the regulator again
    reg_write(OFS_CONFIG, 8'hb8);
    repeat (2) @(posedge clk_sys);
    #1;
    check8({7'h0, ldo_low_current}, 8'h00);
    sleep_cmd <= 1'b0;
    $display("test control bits done");
    // Pin directions for every role code
    for (int r = 0; r < 8; r++)
    begin
      reg_write(OFS_CONFIG, {5'h08, 3'(r)});
      repeat (3) @(posedge clk_sys);
      #1;
      check_pad(sync_pin, dirs[r][5:4]);
      check_pad(sysclk_share_pin, dirs[r][3:2]);
      check_pad(demand_share_pin, dirs[r][1:0]);
    end
    $display("test roles done");
    // Master clock and sync rates
    reg_write(OFS_PERIOD, 8'h04);
    reg_write(OFS_CONFIG, {5'h08, ROLE_MO_MASTER});
    count_rises(1, 50, n);
    check_rng(n, 10, 10);
    count_rises(2, 50, n);
    check_rng(n, 10, 10);
    count_rises(3, 250, n);
    check_rng(n, 10, 10);
    count_rises(0, 250, n);
    check_rng(n, 10, 10);
    reg_write(OFS_CONFIG, {5'h08, ROLE_MP_MASTER});
    sampled_demand <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check8({6'h0, demand_share_pin.o, regulation_demand}, 8'h03);
    sampled_demand <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check8({6'h0, demand_share_pin.o, regulation_demand}, 8'h00);
    $display("test master done");
    // Slave following a peer master
    peer_run <= 1'b1;
    reg_write(OFS_PERIOD_CNT, 8'h00);
    reg_write(OFS_CONFIG, {5'h08, ROLE_MO_SLAVE});
    count_rises(3, 1600, n);
    check_rng(n, 9, 11);
    start_delay(n);
    check_rng(n, 1, 6);
    reg_write(OFS_PHASE_LO, 8'h03);
    start_delay(n);
    check_rng(n, 22, 32);
    reg_write(OFS_CONFIG, {5'h08, ROLE_MO_SLAVE_SYNC});
    start_delay(n);
    check_rng(n, 11, 25);
    reg_write(OFS_PHASE_HI, 8'h01);
    count_rises(3, 1600, n);
    check_rng(n, 0, 0);
    reg_write(OFS_PHASE_HI, 8'h00);
    $display("test slave done");
    // Multi-phase slave takes the shared demand
    reg_write(OFS_CONFIG, 8'h18 | {5'h0, ROLE_MP_SLAVE});
    sampled_demand <= 1'b1;
    peer_dem <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    check8({7'h0, regulation_demand}, 8'h00);
    peer_dem <= 1'b1;
    sampled_demand <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    check8({7'h0, regulation_demand}, 8'h01);
    check8({7'h0, current_regulation_select}, 8'h01);
    $display("test demand done");
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 4500 cycles
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule

`default_nettype wire
